// ==== core/state_framer.sv ====
// state feedback framer core with wishbone register slave
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - send the feedback frame every programmed period of the internal ms timebase, default 1000 ms
// - frame has eight data bytes, extended data page clear, group-extension broadcast
// - default identifier uses priority 6 and pgn 0xFF00
// - inputs 1 to 8 fill byte 1, bits 1 to 8 in order
// - inputs 9 to 12 fill bits 1 to 4 of byte 2
// - relays 1 to 4 fill bits 5 to 8 of byte 2
// - relays 5 to 8 fill bits 1 to 4 of byte 3
// - priority, data page and pgn are programmable
// - source address settable 0 to 253, default 128
// - instance number from allowed list, default 0
module state_framer #(
  parameter int MS_CYC = feedback_pkg::MS_CYCLES
) (
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic [11:0] din,
  input  wire logic [7:0]  relay_state,
  output logic             frame_valid,
  input  wire logic        frame_ready,
  output logic      [28:0] frame_id,
  output logic      [3:0]  frame_dlc,
  output logic      [63:0] frame_data
);
  import feedback_pkg::*;

  typedef struct packed {
    fsm_e        state;
    logic        ack;
    logic [31:0] rdata;
    logic        enable;
    logic [15:0] period;
    logic [2:0]  prio;
    logic        dp;
    logic [7:0]  pf;
    logic [7:0]  ps;
    logic [7:0]  sa;
    logic [2:0]  inst;
    logic        pending;
    logic [28:0] id;
    logic [63:0] data;
    logic [7:0]  count;
  } core_s;

  core_s q;
  core_s next_q;

  sched_if sched ();

  tx_timer #(
    .MS_CYC (MS_CYC)
  ) timer (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .sched   (sched)
  );

  // byte-lane merge of a write onto a register word
  function automatic logic [31:0] merge(
    input logic [31:0] old,
    input logic [31:0] wdat,
    input logic [3:0]  sel
  );
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = wdat[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // word address decode, shared by read and write paths
  function automatic logic is_reg(
    input logic [7:0] adr,
    input logic [7:0] ofs
  );
    return adr[7:2] == ofs[7:2];
  endfunction

  // data field layout; fill bits keep the not-available convention
  function automatic logic [63:0] assemble(
    input logic [11:0] inp,
    input logic [7:0]  rly
  );
    logic [63:0] d;
    d        = {8{FILL_BYTE}};
    d[7:0]   = inp[7:0];
    d[11:8]  = inp[11:8];
    d[15:12] = rly[3:0];
    d[19:16] = rly[7:4];
    d[23:20] = FILL_NIB;
    return d;
  endfunction

  // register words as seen by software
  logic [31:0] ctrl_word;
  logic [31:0] period_word;
  logic [31:0] idcfg_word;
  logic [31:0] addr_word;
  logic [31:0] status_word;
  logic [31:0] lastid_word;

  always_comb begin
    ctrl_word                  = 32'h0000_0000;
    ctrl_word[CTRL_ENABLE_BIT] = q.enable;
    period_word                = {16'h0000, q.period};
    idcfg_word                 = 32'h0000_0000;
    idcfg_word[IDCFG_PRIO_LSB +: 3] = q.prio;
    idcfg_word[IDCFG_DP_BIT]        = q.dp;
    idcfg_word[IDCFG_PF_LSB +: 8]   = q.pf;
    idcfg_word[IDCFG_PS_LSB +: 8]   = q.ps;
    addr_word                       = 32'h0000_0000;
    addr_word[ADDR_SA_LSB +: 8]     = q.sa;
    addr_word[ADDR_INST_LSB +: 3]   = q.inst;
    // live pin states, so software sees what the next frame will carry
    status_word                        = 32'h0000_0000;
    status_word[STAT_DIN_LSB +: 12]    = din;
    status_word[STAT_RELAY_LSB +: 8]   = relay_state;
    status_word[STAT_PEND_BIT]         = q.pending;
    status_word[STAT_COUNT_LSB +: 8]   = q.count;
    lastid_word                        = {3'h0, q.id};
  end

  logic        req;
  logic        wr_now;
  logic [31:0] wm;
  logic        send_now;

  // a write lands on the edge that samples ack high
  assign req    = wb_cyc_i & wb_stb_i;
  assign wr_now = req & wb_we_i & q.ack;

  // next-state logic: bus slave, configuration, framer sequence
  always_comb begin
    next_q   = q;
    wm       = 32'h0000_0000;
    send_now = 1'b0;
    // ack one cycle after the request, dropped the cycle after
    next_q.ack = req & ~q.ack;
    if (req & ~q.ack) begin
      next_q.rdata = 32'h0000_0000;   // unmapped reads give zero
      if (is_reg(wb_adr_i, OFS_CTRL))   next_q.rdata = ctrl_word;
      if (is_reg(wb_adr_i, OFS_PERIOD)) next_q.rdata = period_word;
      if (is_reg(wb_adr_i, OFS_IDCFG))  next_q.rdata = idcfg_word;
      if (is_reg(wb_adr_i, OFS_ADDR))   next_q.rdata = addr_word;
      if (is_reg(wb_adr_i, OFS_STATUS)) next_q.rdata = status_word;
      if (is_reg(wb_adr_i, OFS_LASTID)) next_q.rdata = lastid_word;
    end
    if (wr_now) begin
      if (is_reg(wb_adr_i, OFS_CTRL)) begin
        wm = merge(ctrl_word, wb_dat_i, wb_sel_i);
        next_q.enable = wm[CTRL_ENABLE_BIT];
        send_now = wb_sel_i[0] & wb_dat_i[CTRL_SEND_BIT];
      end
      if (is_reg(wb_adr_i, OFS_PERIOD)) begin
        wm = merge(period_word, wb_dat_i, wb_sel_i);
        next_q.period = wm[15:0];
      end
      if (is_reg(wb_adr_i, OFS_IDCFG)) begin
        wm = merge(idcfg_word, wb_dat_i, wb_sel_i);
        next_q.prio = wm[IDCFG_PRIO_LSB +: 3];
        next_q.dp   = wm[IDCFG_DP_BIT];
        next_q.pf   = wm[IDCFG_PF_LSB +: 8];
        next_q.ps   = wm[IDCFG_PS_LSB +: 8];
      end
      if (is_reg(wb_adr_i, OFS_ADDR)) begin
        wm = merge(addr_word, wb_dat_i, wb_sel_i);
        // out-of-range address is ignored, old value kept
        if (wm[ADDR_SA_LSB +: 8] <= SA_MAX) begin
          next_q.sa = wm[ADDR_SA_LSB +: 8];
        end
        if (wm[ADDR_INST_LSB +: 3] <= INST_MAX) begin
          next_q.inst = wm[ADDR_INST_LSB +: 3];
        end
      end
    end
    // framer sequence
    unique case (q.state)
      ST_IDLE: begin
        if (q.pending) begin
          next_q.state = ST_BUILD;
        end
      end
      ST_BUILD: begin
        // pins sampled here, one cycle before the frame is offered
        next_q.data = assemble(din, relay_state);
        // edp forced clear; dp and pgn from configuration
        next_q.id = {q.prio, 1'b0, q.dp, q.pf, q.ps, q.sa};
        next_q.pending = 1'b0;
        next_q.state   = ST_SEND;
      end
      ST_SEND: begin
        if (frame_ready) begin
          next_q.count = q.count + 8'h01;
          next_q.state = ST_IDLE;
        end
      end
    endcase
    // a request in the clearing cycle is kept: set wins
    if (sched.due | send_now) begin
      next_q.pending = 1'b1;
    end
    if (!rstn) begin
      next_q         = '0;
      next_q.state   = ST_IDLE;
      next_q.enable  = ENABLE_RESET;
      next_q.period  = TX_PERIOD_MS;
      next_q.prio    = PRIO_RESET;
      next_q.dp      = DP_RESET;
      next_q.pf      = PF_RESET;
      next_q.ps      = PS_RESET;
      next_q.sa      = SA_RESET;
      next_q.inst    = INST_RESET;
    end
  end

  // whole state registered in one place
  always_ff @(posedge ref_clk) begin
    q <= next_q;
  end

  // timer steering from software settings
  assign sched.enable    = q.enable;
  assign sched.period_ms = q.period;

  // outputs
  assign wb_ack_o    = q.ack;
  assign wb_dat_o    = q.rdata;
  assign frame_valid = (q.state == ST_SEND);
  assign frame_id    = q.id;
  assign frame_dlc   = FRAME_DLC;
  assign frame_data  = q.data;

  a_dlc_eight: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    frame_valid |-> frame_dlc == FRAME_DLC && frame_id[25] == 1'b0)
    else $error("frame dlc or reserved id bit wrong");

  a_id_from_config: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    $rose(frame_valid) |-> frame_id == {$past(q.prio), 1'b0,
      $past(q.dp), $past(q.pf), $past(q.ps), $past(q.sa)})
    else $error("identifier does not match configuration");

  a_byte1_inputs: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    $rose(frame_valid) |-> frame_data[7:0] == $past(din[7:0]))
    else $error("byte 1 does not hold inputs 1 to 8");

  a_byte2_mix: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    $rose(frame_valid) |-> frame_data[15:8]
      == {$past(relay_state[3:0]), $past(din[11:8])})
    else $error("byte 2 does not hold inputs 9-12 and relays 1-4");

  a_byte3_relays: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    $rose(frame_valid) |-> frame_data[19:16] == $past(relay_state[7:4]))
    else $error("byte 3 does not hold relays 5 to 8");

  a_fill_ones: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    frame_valid |-> frame_data[63:20] == {44{1'b1}})
    else $error("unused frame bits not all ones");

  a_hold_offer: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    frame_valid && !frame_ready |=> frame_valid
      && $stable(frame_data) && $stable(frame_id))
    else $error("frame dropped or changed while stalled");

  a_sa_range: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    q.sa <= SA_MAX)
    else $error("source address above 253");

  a_default_ident: assert property (
    @(posedge ref_clk)
    !rstn |=> q.prio == PRIO_RESET && {q.dp, q.pf, q.ps} == 17'h0FF00
      && q.sa == SA_RESET && q.inst == INST_RESET)
    else $error("reset identity not priority 6 pgn 0xFF00");

  // pending at E+1, build at E+2, offer stands from E+3
  a_due_to_frame: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    sched.due && q.state == ST_IDLE |=> ##2 frame_valid)
    else $error("due did not start a frame in three cycles");

  a_ack_pulse: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  a_ack_next: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    req && !wb_ack_o |=> wb_ack_o)
    else $error("request not acknowledged next cycle");

  a_unmapped_zero: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    req && !wb_ack_o && wb_adr_i[7:2] > OFS_LASTID[7:2] |=> wb_dat_o == 32'h0)
    else $error("unmapped read did not return zero");

  // a refused address write must leave the old value in place
  a_sa_refused: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    wr_now && is_reg(wb_adr_i, OFS_ADDR) && wb_sel_i[0]
      && wb_dat_i[7:0] > SA_MAX |=> q.sa == $past(q.sa))
    else $error("source address above 253 was taken");

  a_pend_set_wins: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    sched.due || send_now |=> q.pending)
    else $error("frame request lost");

  a_valid_drops: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    frame_valid && frame_ready |=> !frame_valid)
    else $error("frame offered again after acceptance");

  a_count_step: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    frame_valid && frame_ready |=> q.count == $past(q.count) + 8'h01)
    else $error("sent frame count did not advance");

  a_stop_no_due: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    !sched.enable |=> !sched.due)
    else $error("due raised while periodic sending is off");

endmodule
`default_nettype wire

// ==== core/feedback_pkg.sv ====
// shared constants and types of the input/relay state feedback framer
package feedback_pkg;

  // timing: system clock period and the millisecond timebase
  localparam int CLK_PERIOD_NS = 8;
  localparam int MS_TIME_NS    = 1000000;
  localparam int MS_CYCLES     = MS_TIME_NS / CLK_PERIOD_NS;
  localparam int PRESC_W       = 17;
  localparam logic [15:0] TX_PERIOD_MS = 16'h03E8;  // 1000 ms

  // register byte offsets on the wishbone slave
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_PERIOD = 8'h04;
  localparam logic [7:0] OFS_IDCFG  = 8'h08;
  localparam logic [7:0] OFS_ADDR   = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_LASTID = 8'h14;

  // control register fields
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_SEND_BIT   = 1;

  // identifier configuration fields
  localparam int IDCFG_PRIO_LSB = 0;
  localparam int IDCFG_DP_BIT   = 3;
  localparam int IDCFG_PF_LSB   = 4;
  localparam int IDCFG_PS_LSB   = 12;

  // address register fields
  localparam int ADDR_SA_LSB   = 0;
  localparam int ADDR_INST_LSB = 8;

  // status register fields
  localparam int STAT_DIN_LSB   = 0;
  localparam int STAT_RELAY_LSB = 12;
  localparam int STAT_PEND_BIT  = 20;
  localparam int STAT_COUNT_LSB = 24;

  // reset values of enable and the frame identity, and address field limits
  localparam logic       ENABLE_RESET = 1'b1;
  localparam logic [2:0] PRIO_RESET   = 3'h6;
  localparam logic       DP_RESET     = 1'b0;
  localparam logic [7:0] PF_RESET     = 8'hFF;  // pgn 0xFF00
  localparam logic [7:0] PS_RESET     = 8'h00;
  localparam logic [7:0] SA_RESET     = 8'h80;
  localparam logic [7:0] SA_MAX       = 8'hFD;  // 253
  localparam logic [2:0] INST_RESET   = 3'h0;
  localparam logic [2:0] INST_MAX     = 3'h7;

  // frame format
  localparam logic [3:0]  FRAME_DLC = 4'h8;
  localparam logic [7:0]  FILL_BYTE = 8'hFF;
  localparam logic [3:0]  FILL_NIB  = 4'hF;

  // framer sequence, one-hot
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_BUILD = 3'b010,
    ST_SEND  = 3'b100
  } fsm_e;

endpackage

// ==== core/sched_if.sv ====
// link between the framer core and its millisecond transmit timer
`timescale 1ns/1ps
`default_nettype none
interface sched_if;
  logic        enable;
  logic [15:0] period_ms;
  logic        due;

  modport timer (input enable, input period_ms, output due);
  modport core  (output enable, output period_ms, input due);
endinterface
`default_nettype wire

// ==== core/tx_timer.sv ====
// millisecond timebase and transmit repetition timer
`timescale 1ns/1ps
`default_nettype none
module tx_timer #(
  parameter int MS_CYC = feedback_pkg::MS_CYCLES
) (
  input  wire logic ref_clk,
  input  wire logic rstn,
  sched_if.timer    sched
);
  import feedback_pkg::*;

  typedef struct packed {
    logic [PRESC_W-1:0] presc;
    logic [15:0]        ms;
    logic               due;
  } timer_s;

  timer_s q;
  timer_s next_q;

  // prescaler makes the ms tick, ms counter makes the repetition
  always_comb begin
    next_q     = q;
    next_q.due = 1'b0;
    if (!sched.enable || sched.period_ms == 16'h0000) begin
      next_q.presc = '0;
      next_q.ms    = 16'h0000;
    end else if (q.presc == PRESC_W'(MS_CYC - 1)) begin
      next_q.presc = '0;
      if (q.ms >= sched.period_ms - 16'h0001) begin
        next_q.ms  = 16'h0000;
        next_q.due = 1'b1;
      end else begin
        next_q.ms = q.ms + 16'h0001;
      end
    end else begin
      next_q.presc = q.presc + PRESC_W'(1);
    end
    if (!rstn) begin
      next_q = '0;
    end
  end

  always_ff @(posedge ref_clk) begin
    q <= next_q;
  end

  assign sched.due = q.due;

  a_due_on_tick: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    q.due |-> $past(q.presc) == PRESC_W'(MS_CYC - 1)
      && $past(q.ms) >= $past(sched.period_ms) - 16'h0001)
    else $error("due raised off the millisecond period");

  a_due_single: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    q.due |=> !q.due)
    else $error("due longer than one cycle");

endmodule
`default_nettype wire

// ==== tb/frame_sink.sv ====
// model of the network side that takes feedback frames off the framer
`timescale 1ns/1ps
`default_nettype none
module frame_sink (
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  input  wire logic        frame_valid,
  input  wire logic [28:0] frame_id,
  input  wire logic [3:0]  frame_dlc,
  input  wire logic [63:0] frame_data,
  input  wire logic [3:0]  stall,
  output logic             frame_ready,
  output logic      [28:0] got_id,
  output logic      [3:0]  got_dlc,
  output logic      [63:0] got_data,
  output int unsigned      count,
  output logic             changed
);
  logic [3:0]  wait_cnt;
  logic        held;
  logic [91:0] prev;
  // stall a programmable number of cycles, then take the frame;
  // a frame that moves while offered is flagged, a real bus needs it still
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      frame_ready <= 1'b0;
      wait_cnt    <= '0;
      count       <= 0;
      changed     <= 1'b0;
      held        <= 1'b0;
    end else begin
      held <= frame_valid && !frame_ready;
      prev <= {frame_id, frame_data};
      if (frame_valid && frame_ready) begin
        got_id      <= frame_id;
        got_dlc     <= frame_dlc;
        got_data    <= frame_data;
        count       <= count + 1;
        frame_ready <= 1'b0;
        wait_cnt    <= '0;
      end else if (frame_valid) begin
        if (wait_cnt >= stall) frame_ready <= 1'b1;
        else wait_cnt <= wait_cnt + 4'h1;
        if (held && prev !== {frame_id, frame_data}) changed <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
// self-checking bench of the state feedback framer
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import feedback_pkg::*;
  logic        ref_clk = 1'b0;
  logic        rstn    = 1'b0;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0]  adr  = 8'h00;
  logic [3:0]  sel  = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic        ack;
  logic [11:0] din   = 12'h9A5;
  logic [7:0]  relay = 8'hC3;
  logic [3:0]  stall = 4'h0;
  logic        fv, fr, changed;
  logic [28:0] fid, got_id;
  logic [3:0]  fdlc, got_dlc;
  logic [63:0] fdata, got_data;
  int unsigned cnt;
  int          num_errors = 0, num_checks = 0, now = 0, t0, i;
  logic [11:0] pd [4] = '{12'h001, 12'h800, 12'hF0F, 12'h5A3};
  logic [7:0]  pr [4] = '{8'h01, 8'h80, 8'h5A, 8'hF0};

  // ms counts shortened so a 1000 ms period fits the run
  state_framer #(.MS_CYC(4)) uut (.ref_clk(ref_clk), .rstn(rstn),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .din(din), .relay_state(relay), .frame_valid(fv), .frame_ready(fr),
    .frame_id(fid), .frame_dlc(fdlc), .frame_data(fdata));
  frame_sink sink (.ref_clk(ref_clk), .rstn(rstn), .frame_valid(fv),
    .frame_id(fid), .frame_dlc(fdlc), .frame_data(fdata), .stall(stall),
    .frame_ready(fr), .got_id(got_id), .got_dlc(got_dlc),
    .got_data(got_data), .count(cnt), .changed(changed));

  always #4 ref_clk = ~ref_clk;
  always @(posedge ref_clk) now <= now + 1;

  task results;
    if (num_errors == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task check(input logic [63:0] got, input logic [63:0] exp, input string s);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: %s got %h want %h", $time, s, got, exp);
    end
  endtask
  task fail(input string s);
    num_errors++;
    $display("unexpected at %0t: %s", $time, s);
    results();
  endtask
  // one classic cycle; request held until ack is sampled high
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d,
          output logic [31:0] q);
    int k;
    @(posedge ref_clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= 4'hF;
    for (k = 0; k < 20; k++) begin
      @(posedge ref_clk);
      if (ack === 1'b1) break;
    end
    if (k == 20) fail("bus answer missing");
    q = rdat;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task rdchk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    check(q & m, exp, "register read");
  endtask
  task wait_frames(input int unsigned n);
    int k;
    for (k = 0; k < 20000; k++) begin
      @(posedge ref_clk);
      if (cnt >= n) break;
    end
    if (k == 20000) fail("frame missing");
  endtask
  function automatic logic [28:0] xid(logic [2:0] p, logic dp,
      logic [7:0] pf, logic [7:0] ps, logic [7:0] sa);
    return {p, 1'b0, dp, pf, ps, sa};
  endfunction
  // unused bits go out as ones, a receiver reads them as not available
  function automatic logic [63:0] xdata(logic [11:0] d, logic [7:0] r);
    return {44'hFFFFFFFFFFF, r, d};
  endfunction
  task frame_check(input logic [28:0] eid, input logic [63:0] edat);
    check(got_id, eid, "frame id");
    check(got_dlc, 4'h8, "frame length");
    check(got_data, edat, "frame data");
    check(changed, 1'b0, "frame moved while offered");
  endtask

  initial begin
    repeat (3) @(posedge ref_clk);
    rstn <= 1'b1;
    t0 = now;
    rdchk(OFS_CTRL, 32'h1, 32'hFFFFFFFF);
    rdchk(OFS_PERIOD, 32'h3E8, 32'hFFFFFFFF);
    rdchk(OFS_IDCFG, 32'hFF6, 32'hFFFFFFFF);
    rdchk(OFS_ADDR, 32'h80, 32'hFFFFFFFF);
    rdchk(OFS_STATUS, {12'h0, relay, din}, 32'h000FFFFF);
    rdchk(8'h18, 32'h0, 32'hFFFFFFFF);
    // first frame one full 1000 ms period after reset
    wait_frames(1);
    check((now - t0) >= 4000 && (now - t0) <= 4012, 1'b1, "period");
    frame_check(xid(3'h6, 1'b0, 8'hFF, 8'h00, 8'h80), xdata(12'h9A5, 8'hC3));
    rdchk(OFS_LASTID, {3'h0, xid(3'h6, 1'b0, 8'hFF, 8'h00, 8'h80)}, 32'hFFFFFFFF);
    rdchk(OFS_STATUS, 32'h01000000, 32'hFF000000);
    wr(OFS_CTRL, 32'h0);
    wr(OFS_ADDR, 32'h7FD);
    rdchk(OFS_ADDR, 32'h7FD, 32'hFFFFFFFF);
    // address 254 is refused while the instance field still lands
    wr(OFS_ADDR, 32'h0FE);
    rdchk(OFS_ADDR, 32'h0FD, 32'hFFFFFFFF);
    wr(OFS_IDCFG, 32'h12FEB);
    rdchk(OFS_IDCFG, 32'h12FEB, 32'hFFFFFFFF);
    // walking patterns sent on demand, taker prompt and slow in turn
    for (i = 0; i < 4; i++) begin
      din   <= pd[i];
      relay <= pr[i];
      stall <= i[0] ? 4'h5 : 4'h0;
      wr(OFS_CTRL, 32'h2);
      wait_frames(2 + i);
      frame_check(xid(3'h3, 1'b1, 8'hFE, 8'h12, 8'hFD), xdata(pd[i], pr[i]));
    end
    // short period set while stopped, so a broken enable would show
    wr(OFS_PERIOD, 32'h2);
    repeat (50) @(posedge ref_clk);
    check(cnt, 5, "frame count while stopped");
    stall <= 4'h0;
    wr(OFS_CTRL, 32'h1);
    wait_frames(6);
    t0 = now;
    wait_frames(7);
    check((now - t0) >= 7 && (now - t0) <= 9, 1'b1, "short period");
    // reset in mid-run brings back the default identity and counts
    rstn <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rstn <= 1'b1;
    rdchk(OFS_IDCFG, 32'hFF6, 32'hFFFFFFFF);
    rdchk(OFS_ADDR, 32'h80, 32'hFFFFFFFF);
    rdchk(OFS_STATUS, 32'h0, 32'hFF100000);
    results();
  end
endmodule
`default_nettype wire
